// ==== bbfs_top.sv ====
// Fault supervision and mode control of backlight and bias power
//
// Overview of operation
// R1: Short policy one: flag, turn off channel
// R2: Short policy zero: flag, keep channel running
// R3: Over-voltage stops boost and sets flag
// R4: Report-only policy: resume boost below threshold
// R5: Off policy: disable low-headroom enabled sinks
// R6: Disabled sinks stay off until reset
// R7: All open: all sinks off, boost stopped
// R8: Current trip kills low side rest of cycle
// R9: Enough trips set the overcurrent flag
// R10: Rail voltages apply on bias config rewrite
// R11: Pin control enables rails from pins
// R12: Register control enables rails from bits
// R13: Discharge at shutdown per enable bit
// R14: Positive rail short flag after filter
// R15: Short flag held until host reads
// R16: Short policy: flag, bias off, all off
// R17: Short filter selectable, four durations
// R18: Soft reset restores defaults, self clears
// R19: Undervoltage stops stages, keeps settings
// R20: Thermal trip stops stages, flag real time
// R21: Enable low: shutdown, writes ignored
// R22: Policy bit zero reports, one disables
// R23: Persistence counter restarts on drop
`timescale 1ns/1ps
`include "bbfs_defines.svh"
module bbfs_top #(
  parameter int NCH       = 4,
  parameter int SHORT_CYC = `BBFS_SHORT_CYC,
  parameter int FLT0_CYC  = `BBFS_FLT0_CYC,
  parameter int FLT1_CYC  = `BBFS_FLT1_CYC,
  parameter int FLT2_CYC  = `BBFS_FLT2_CYC,
  parameter int FLT3_CYC  = `BBFS_FLT3_CYC,
  parameter int OCP_TRIPS = `BBFS_OCP_TRIPS
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   resetn_i,
  input  wire logic                   hw_enable_pin_i,
  input  wire logic                   pos_rail_enable_pin_i,
  input  wire logic                   neg_rail_enable_pin_i,
  input  wire logic [NCH-1:0]         sink_overvolt_i,
  input  wire logic [NCH-1:0]         sink_low_headroom_i,
  input  wire logic [NCH-1:0]         sink_enable_i,
  input  wire logic                   bl_overvolt_i,
  input  wire logic                   bl_overcurrent_i,
  input  wire logic                   sw_cycle_start_i,
  input  wire logic                   pos_rail_overload_i,
  input  wire logic                   uvlo_i,
  input  wire logic                   thermal_i,
  input  wire logic                   bl_mode_reset_i,
  input  wire logic                   host_write_i,
  input  wire logic                   soft_reset_bit_i,
  input  wire logic                   bias_cfg_write_i,
  input  wire bbfs_pkg::bbfs_bias_cfg_t bias_cfg_i,
  input  wire logic [5:0]             pos_rail_code_i,
  input  wire logic [5:0]             neg_rail_code_i,
  input  wire logic [5:0]             bias_boost_code_i,
  input  wire logic                   short_policy_sel_i,
  input  wire logic                   overvolt_policy_i,
  input  wire logic [1:0]             ocp_limit_sel_i,
  input  wire logic [1:0]             rail_short_policy_i,
  input  wire logic [1:0]             rail_short_filter_i,
  input  wire logic                   flag_read_i,
  output logic                        regs_reset_o,
  output logic                        soft_reset_clear_o,
  output bbfs_pkg::bbfs_mode_t        mode_o,
  output bbfs_pkg::bbfs_flags_t       flags_o,
  output logic [NCH-1:0]              sink_on_o,
  output logic                        bl_boost_run_o,
  output logic                        low_side_block_o,
  output logic [1:0]                  ocp_limit_o,
  output logic                        pos_rail_on_o,
  output logic                        neg_rail_on_o,
  output logic                        bias_boost_run_o,
  output logic                        pos_discharge_o,
  output logic                        neg_discharge_o,
  output logic [5:0]                  pos_rail_code_o,
  output logic [5:0]                  neg_rail_code_o,
  output logic [5:0]                  bias_boost_code_o
);
  initial
  begin
    if (NCH < 1 || NCH > 8 || SHORT_CYC < 2 || FLT0_CYC < 2 ||
        OCP_TRIPS < 1 || OCP_TRIPS > 255)
      $error("bbfs_top: unsupported parameter value");
  end

  logic       rst_q1, rst_n;
  logic [2:0] sync1, sync2;
  logic [NCH-1:0] sov_s1, sov_s2;
  logic [NCH-1:0] hdr_s1, hdr_s2;
  logic [4:0] ev_s1, ev_s2;
  logic       hw_en, en_p, en_n;
  logic       ovp, ocp, rail_ovl, uvlo, hot;

  // Reset release through two flops
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // Every analog comparator is asynchronous to this clock
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1  <= 3'h0;
      sync2  <= 3'h0;
      sov_s1 <= '0;
      sov_s2 <= '0;
      hdr_s1 <= '0;
      hdr_s2 <= '0;
      ev_s1  <= 5'h00;
      ev_s2  <= 5'h00;
    end
    else
    begin
      sync1  <= {hw_enable_pin_i, pos_rail_enable_pin_i,
                 neg_rail_enable_pin_i};
      sync2  <= sync1;
      sov_s1 <= sink_overvolt_i;
      sov_s2 <= sov_s1;
      hdr_s1 <= sink_low_headroom_i;
      hdr_s2 <= hdr_s1;
      ev_s1  <= {bl_overvolt_i, bl_overcurrent_i, pos_rail_overload_i,
                 uvlo_i, thermal_i};
      ev_s2  <= ev_s1;
    end
  end
  assign {hw_en, en_p, en_n}          = sync2;
  assign {ovp, ocp, rail_ovl, uvlo, hot} = ev_s2;

  // Enable low clears config, flags, counters and latches, but not the low-side block; soft reset does the same
  logic hw_en_q, soft_rst, clr;
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      hw_en_q <= 1'b0;
    else
      hw_en_q <= hw_en;
  end
  assign soft_rst = hw_en && host_write_i && soft_reset_bit_i; // [R18]
  assign clr      = !hw_en || soft_rst;                        // [R21]
  assign regs_reset_o       = clr;
  assign soft_reset_clear_o = soft_rst;                        // [R18]

  // Mode
  logic any_rail_req, bl_active;
  bbfs_pkg::bbfs_bias_cfg_t cfg;
  logic stage_kill;
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      mode_o <= bbfs_pkg::BBFS_SHUTDOWN;
    else if (!hw_en)
      mode_o <= bbfs_pkg::BBFS_SHUTDOWN;                       // [R21]
    else if (any_rail_req || bl_active)
      mode_o <= bbfs_pkg::BBFS_NORMAL;
    else
      mode_o <= bbfs_pkg::BBFS_STANDBY;                        // [R21]
  end
  assign bl_active = |sink_enable_i;

  // Bias configuration and latched voltage codes
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg             <= '0;
      pos_rail_code_o <= 6'h00;
      neg_rail_code_o <= 6'h00;
    end
    else if (clr)
    begin
      cfg             <= '0;
      pos_rail_code_o <= 6'h00;
      neg_rail_code_o <= 6'h00;
    end
    else if (bias_cfg_write_i)
    begin
      cfg             <= bias_cfg_i;
      pos_rail_code_o <= pos_rail_code_i;                      // [R10]
      neg_rail_code_o <= neg_rail_code_i;                      // [R10]
    end
  end
  assign bias_boost_code_o = bias_boost_code_i;                // [R10]

  // Rail enable decode
  logic req_p, req_n;
  always_comb
  begin
    if (cfg.pin_control_select)
    begin
      req_p = en_p;                                            // [R11]
      req_n = en_n;                                            // [R11]
    end
    else if (cfg.bias_enable_mode)
    begin
      req_p = cfg.pos_rail_sw_enable;                          // [R12]
      req_n = cfg.neg_rail_sw_enable;                          // [R12]
    end
    else
    begin
      req_p = 1'b0;
      req_n = 1'b0;
    end
  end
  assign any_rail_req = req_p || req_n;

  // Positive rail short filter
  logic [31:0] flt_cnt, flt_lim;
  logic        rail_short_ev, bias_kill, all_kill;
  always_comb
  begin
    unique case (rail_short_filter_i)                          // [R17]
      2'h0: flt_lim = 32'(FLT0_CYC);
      2'h1: flt_lim = 32'(FLT1_CYC);
      2'h2: flt_lim = 32'(FLT2_CYC);
      2'h3: flt_lim = 32'(FLT3_CYC);
    endcase
  end
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      flt_cnt <= 32'h0;
    else if (!rail_ovl || clr)
      flt_cnt <= 32'h0;
    else if (flt_cnt < flt_lim)
      flt_cnt <= flt_cnt + 32'h1;
  end
  assign rail_short_ev = rail_ovl && (flt_cnt == flt_lim - 32'h1); // [R14]

  // Flags; set wins over clearing read
  logic [NCH-1:0] short_ev;
  logic [7:0]     ocp_cnt;
  logic           ocp_ev;
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      flags_o <= '0;
    else if (clr)
      flags_o <= '0;
    else
    begin
      flags_o.thermal_trip_flag <= hot;                        // [R20]
      if (rail_short_ev)
        flags_o.pos_rail_short_flag <= 1'b1;                   // [R14]
      else if (flag_read_i)
        flags_o.pos_rail_short_flag <= 1'b0;                   // [R15]
      if (ovp)
        flags_o.bl_overvolt_flag <= 1'b1;                      // [R3]
      else if (flag_read_i)
        flags_o.bl_overvolt_flag <= 1'b0;
      if (|short_ev)
        flags_o.sink_short_flag <= 1'b1;                       // [R1] [R2]
      else if (flag_read_i)
        flags_o.sink_short_flag <= 1'b0;
      if (ocp_ev)
        flags_o.bl_overcurrent_flag <= 1'b1;                   // [R9]
      else if (flag_read_i)
        flags_o.bl_overcurrent_flag <= 1'b0;
    end
  end

  // Short consequence latched until reset
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bias_kill <= 1'b0;
      all_kill  <= 1'b0;
    end
    else if (clr)
    begin
      bias_kill <= 1'b0;
      all_kill  <= 1'b0;
    end
    else if (rail_short_ev)
    begin
      if (rail_short_policy_i != `BBFS_POL_FLAG)
        bias_kill <= 1'b1;                                     // [R16]
      if (rail_short_policy_i == `BBFS_POL_ALL)
        all_kill <= 1'b1;                                      // [R16]
    end
  end

  // Per-channel short persistence and latched sink disables
  logic [31:0]    sov_cnt [NCH];
  logic [NCH-1:0] sink_off, bl_rst;
  assign bl_rst = {NCH{clr || bl_mode_reset_i}};
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      always_ff @(posedge clk_sys_i or negedge rst_n)
      begin
        if (!rst_n)
          sov_cnt[g] <= 32'h0;
        else if (!sov_s2[g] || bl_rst[g])
          sov_cnt[g] <= 32'h0;                                 // [R23]
        else if (sov_cnt[g] < 32'(SHORT_CYC))
          sov_cnt[g] <= sov_cnt[g] + 32'h1;                    // [R23]
      end
      assign short_ev[g] = sov_s2[g] &&
                           (sov_cnt[g] == 32'(SHORT_CYC) - 32'h1);
      always_ff @(posedge clk_sys_i or negedge rst_n)
      begin
        if (!rst_n)
          sink_off[g] <= 1'b0;
        else if (bl_rst[g])
          sink_off[g] <= 1'b0;                                 // [R6]
        else if (short_ev[g] && short_policy_sel_i)
          sink_off[g] <= 1'b1;                                 // [R1]
        else if (ovp && overvolt_policy_i && sink_enable_i[g] &&
                 hdr_s2[g])
          sink_off[g] <= 1'b1;                                 // [R5] [R22]
      end
    end
  endgenerate

  // All open: whole backlight held off
  logic all_open;
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      all_open <= 1'b0;
    else if (clr || bl_mode_reset_i)
      all_open <= 1'b0;                                        // [R7]
    else if (ovp && bl_active && ((hdr_s2 & sink_enable_i) == sink_enable_i))
      all_open <= 1'b1;                                        // [R7]
  end

  // Overcurrent: cycle blanking and trip counter
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      low_side_block_o <= 1'b0;
    else if (ocp)
      low_side_block_o <= 1'b1;                                // [R8]
    else if (sw_cycle_start_i)
      low_side_block_o <= 1'b0;                                // [R8]
  end
  logic ocp_q;
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ocp_q   <= 1'b0;
      ocp_cnt <= 8'h00;
    end
    else
    begin
      ocp_q <= ocp;
      if (clr)
        ocp_cnt <= 8'h00;
      else if (ocp && !ocp_q && ocp_cnt < 8'(OCP_TRIPS))
        ocp_cnt <= ocp_cnt + 8'h01;
    end
  end
  assign ocp_ev = ocp && !ocp_q && (ocp_cnt == 8'(OCP_TRIPS) - 8'h01);
  assign ocp_limit_o = ocp_limit_sel_i;                        // [R8]

  // Power stage gating; thermal covers the short policy zero case
  assign stage_kill = !hw_en || uvlo || hot;                   // [R19] [R20]
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sink_on_o        <= '0;
      bl_boost_run_o   <= 1'b0;
      pos_rail_on_o    <= 1'b0;
      neg_rail_on_o    <= 1'b0;
      bias_boost_run_o <= 1'b0;
      pos_discharge_o  <= 1'b0;
      neg_discharge_o  <= 1'b0;
    end
    else
    begin
      sink_on_o <= (stage_kill || all_kill || all_open) ? '0 :
                   (sink_enable_i & ~sink_off);                // [R2] [R4]
      bl_boost_run_o <= bl_active && !stage_kill && !all_kill &&
                        !all_open && !ovp;                     // [R3] [R4]
      pos_rail_on_o    <= req_p && !stage_kill && !bias_kill;
      neg_rail_on_o    <= req_n && !stage_kill && !bias_kill;
      bias_boost_run_o <= any_rail_req && !stage_kill && !bias_kill;
      // Selection caught on the way down; defaults load right after
      pos_discharge_o  <= !hw_en &&
                          (hw_en_q ? cfg.pos_discharge_en
                                   : pos_discharge_o);         // [R13]
      neg_discharge_o  <= !hw_en &&
                          (hw_en_q ? cfg.neg_discharge_en
                                   : neg_discharge_o);         // [R13]
    end
  end

  // Checks
  ovp_stop_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    ovp |=> !bl_boost_run_o && flags_o.bl_overvolt_flag) // [R3]
    else $error("boost ran during over-voltage");
  flag_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    flags_o.pos_rail_short_flag && !flag_read_i && hw_en && !soft_rst
    |=> flags_o.pos_rail_short_flag) // [R15]
    else $error("short flag dropped without read");
  therm_track_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    hw_en && !soft_rst |=> flags_o.thermal_trip_flag == $past(hot)) // [R20]
    else $error("thermal flag not real time");
  therm_off_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    hot |=> sink_on_o == '0 && !pos_rail_on_o && !bias_boost_run_o) // [R20]
    else $error("stages on while hot");
  uvlo_off_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    uvlo |=> sink_on_o == '0 && !bl_boost_run_o) // [R19]
    else $error("stages on in undervoltage");
  shutdown_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    !hw_en |=> mode_o == bbfs_pkg::BBFS_SHUTDOWN && flags_o == '0) // [R21]
    else $error("not in shutdown with enable low");
  pin_ctl_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    cfg.pin_control_select && !stage_kill && !bias_kill
    |=> pos_rail_on_o == $past(en_p)) // [R11]
    else $error("positive rail not following pin");
  ocp_block_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    ocp ##1 !sw_cycle_start_i |-> low_side_block_o) // [R8]
    else $error("low side not blocked after trip");
  dis_sel_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    hw_en |=> !pos_discharge_o && !neg_discharge_o) // [R13]
    else $error("discharge active while enabled");
  short_cov: cover property (@(posedge clk_sys_i) |short_ev);
  rail_cov:  cover property (@(posedge clk_sys_i) rail_short_ev);
  ocp_cov:   cover property (@(posedge clk_sys_i) ocp_ev);
  open_cov:  cover property (@(posedge clk_sys_i) all_open);
endmodule : bbfs_top

// ==== bbfs_defines.svh ====
// Constants for the backlight and bias fault supervisor
`ifndef BBFS_DEFINES_SVH
`define BBFS_DEFINES_SVH
`define BBFS_CLK_MHZ        125
`define BBFS_SHORT_MS       59
`define BBFS_SHORT_CYC      (`BBFS_SHORT_MS * 1000 * `BBFS_CLK_MHZ)
`define BBFS_FLT0_US        100
`define BBFS_FLT1_US        500
`define BBFS_FLT2_US        1000
`define BBFS_FLT3_US        2000
`define BBFS_FLT0_CYC       (`BBFS_FLT0_US * `BBFS_CLK_MHZ)
`define BBFS_FLT1_CYC       (`BBFS_FLT1_US * `BBFS_CLK_MHZ)
`define BBFS_FLT2_CYC       (`BBFS_FLT2_US * `BBFS_CLK_MHZ)
`define BBFS_FLT3_CYC       (`BBFS_FLT3_US * `BBFS_CLK_MHZ)
`define BBFS_OCP_TRIPS      8
`define BBFS_POL_FLAG       2'h0
`define BBFS_POL_BIAS       2'h1
`define BBFS_POL_ALL        2'h2
`endif

// ==== bbfs_pkg.sv ====
// Types for the backlight and bias fault supervisor
package bbfs_pkg;
  typedef enum logic [2:0] {
    BBFS_SHUTDOWN = 3'h1,
    BBFS_STANDBY  = 3'h2,
    BBFS_NORMAL   = 3'h4
  } bbfs_mode_t;
  typedef struct packed {
    logic thermal_trip_flag;
    logic pos_rail_short_flag;
    logic bl_overvolt_flag;
    logic sink_short_flag;
    logic bl_overcurrent_flag;
  } bbfs_flags_t;
  typedef struct packed {
    logic pin_control_select;
    logic bias_enable_mode;
    logic pos_rail_sw_enable;
    logic neg_rail_sw_enable;
    logic pos_discharge_en;
    logic neg_discharge_en;
  } bbfs_bias_cfg_t;
endpackage : bbfs_pkg

// ==== bbfs_host_model.sv ====
// Host side model issuing register writes and flag reads
`timescale 1ns/1ps
module bbfs_host_model (
  input  wire logic                   clk_sys_i,
  output logic                        host_write_o,
  output logic                        soft_reset_bit_o,
  output logic                        bias_cfg_write_o,
  output bbfs_pkg::bbfs_bias_cfg_t    bias_cfg_o,
  output logic [5:0]                  pos_rail_code_o,
  output logic [5:0]                  neg_rail_code_o,
  output logic                        flag_read_o
);
  initial
  begin
    host_write_o     = 1'b0;
    soft_reset_bit_o = 1'b0;
    bias_cfg_write_o = 1'b0;
    bias_cfg_o       = '0;
    pos_rail_code_o  = 6'h1E;
    neg_rail_code_o  = 6'h1C;
    flag_read_o      = 1'b0;
  end

  // write_bias changes config and codes together with the write strobe
  task automatic write_bias(input bbfs_pkg::bbfs_bias_cfg_t cfg,
                            input logic [5:0] pcode,
                            input logic [5:0] ncode);
    @(posedge clk_sys_i);
    bias_cfg_o       <= cfg;
    pos_rail_code_o  <= pcode;
    neg_rail_code_o  <= ncode;
    bias_cfg_write_o <= 1'b1;
    @(posedge clk_sys_i);
    bias_cfg_write_o <= 1'b0;
  endtask : write_bias

  task automatic soft_reset();
    @(posedge clk_sys_i);
    host_write_o     <= 1'b1;
    soft_reset_bit_o <= 1'b1;
    @(posedge clk_sys_i);
    host_write_o     <= 1'b0;
    soft_reset_bit_o <= 1'b0;
  endtask : soft_reset

  // Sticky flags clear when the host reads them back, or on soft reset or enable low
  task automatic read_flags();
    @(posedge clk_sys_i);
    flag_read_o <= 1'b1;
    @(posedge clk_sys_i);
    flag_read_o <= 1'b0;
  endtask : read_flags
endmodule : bbfs_host_model

// ==== bbfs_top_tb.sv ====
// Self-checking testbench of the fault supervisor
`timescale 1ns/1ps
module bbfs_top_tb;
  logic                        clk_sys_i = 1'b0;
  logic                        resetn_i = 1'b0;
  logic                        hw_en = 1'b0;
  logic                        pos_pin = 1'b0;
  logic                        neg_pin = 1'b0;
  logic [3:0]                  sov = 4'h0;
  logic [3:0]                  lowhr = 4'h0;
  logic [3:0]                  sen = 4'h0;
  logic                        ovp = 1'b0;
  logic                        ocp = 1'b0;
  logic                        cyc = 1'b0;
  logic                        overload = 1'b0;
  logic                        uvlo = 1'b0;
  logic                        therm = 1'b0;
  logic                        blrst = 1'b0;
  logic                        spol = 1'b0;
  logic                        opol = 1'b0;
  logic [1:0]                  ocsel = 2'h0;
  logic [1:0]                  rspol = 2'h0;
  logic [1:0]                  rsflt = 2'h3;
  logic [5:0]                  bcode = 6'h28;
  logic                        hw, srb, bw, fr, rr, src;
  logic [5:0]                  pc, nc;
  bbfs_pkg::bbfs_bias_cfg_t    cfg;
  bbfs_pkg::bbfs_mode_t        mode;
  bbfs_pkg::bbfs_flags_t       fl;
  logic [3:0]                  son;
  logic                        brun, lsb, pon, non, bbrun, pdis, ndis;
  logic [1:0]                  ocl;
  logic [5:0]                  pco, nco, bco;
  int                          errors = 0;
  int                          cmp_count = 0;
  logic                        sr_seen = 1'b0;

  always #4 clk_sys_i = ~clk_sys_i;

  bbfs_host_model host (.clk_sys_i(clk_sys_i), .host_write_o(hw),
    .soft_reset_bit_o(srb), .bias_cfg_write_o(bw), .bias_cfg_o(cfg),
    .pos_rail_code_o(pc), .neg_rail_code_o(nc), .flag_read_o(fr));

  bbfs_top #(.SHORT_CYC(20), .FLT0_CYC(4), .FLT1_CYC(6), .FLT2_CYC(8),
    .FLT3_CYC(10)) uut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .hw_enable_pin_i(hw_en), .pos_rail_enable_pin_i(pos_pin),
    .neg_rail_enable_pin_i(neg_pin), .sink_overvolt_i(sov),
    .sink_low_headroom_i(lowhr), .sink_enable_i(sen), .bl_overvolt_i(ovp),
    .bl_overcurrent_i(ocp), .sw_cycle_start_i(cyc),
    .pos_rail_overload_i(overload), .uvlo_i(uvlo), .thermal_i(therm),
    .bl_mode_reset_i(blrst), .host_write_i(hw), .soft_reset_bit_i(srb),
    .bias_cfg_write_i(bw), .bias_cfg_i(cfg), .pos_rail_code_i(pc),
    .neg_rail_code_i(nc), .bias_boost_code_i(bcode),
    .short_policy_sel_i(spol), .overvolt_policy_i(opol),
    .ocp_limit_sel_i(ocsel), .rail_short_policy_i(rspol),
    .rail_short_filter_i(rsflt), .flag_read_i(fr), .regs_reset_o(rr),
    .soft_reset_clear_o(src), .mode_o(mode), .flags_o(fl), .sink_on_o(son),
    .bl_boost_run_o(brun), .low_side_block_o(lsb), .ocp_limit_o(ocl),
    .pos_rail_on_o(pon), .neg_rail_on_o(non), .bias_boost_run_o(bbrun),
    .pos_discharge_o(pdis), .neg_discharge_o(ndis), .pos_rail_code_o(pco),
    .neg_rail_code_o(nco), .bias_boost_code_o(bco));

  always @(posedge clk_sys_i)
    if (src === 1'b1 && rr === 1'b1)
      sr_seen <= 1'b1;

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : cyc_wait

  task automatic chk(input logic [5:0] got, input logic [5:0] exp,
                     input string msg);
    cmp_count++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t %s", $time, msg);
      errors++;
    end
  endtask : chk

  task automatic end_of_test();
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task automatic t_bias();
    bbfs_pkg::bbfs_bias_cfg_t c;
    c = '0;
    c.pin_control_select = 1'b1;
    c.bias_enable_mode = 1'b1;
    host.write_bias(c, 6'h10, 6'h11);
    @(posedge clk_sys_i);
    pos_pin <= 1'b1;
    cyc_wait(6);
    chk(pon, 1, "pin pos on");
    chk(non, 0, "pin neg off");
    chk(pco, 6'h10, "pos code at write");
    c.pin_control_select = 1'b0;
    c.neg_rail_sw_enable = 1'b1;
    c.pos_discharge_en = 1'b1;
    host.write_bias(c, 6'h10, 6'h11);
    cyc_wait(4);
    chk(pon, 0, "sw pos off");
    chk(non, 1, "sw neg on");
    @(posedge clk_sys_i);
    bcode <= 6'h33;
    pos_pin <= 1'b0;
    cyc_wait(1);
    chk(bco, 6'h33, "boost code now");
    @(posedge clk_sys_i);
    host.pos_rail_code_o <= 6'h2A;
    cyc_wait(4);
    chk(pco, 6'h10, "pos code held");
  endtask : t_bias

  task automatic t_short();
    @(posedge clk_sys_i);
    spol <= 1'b1;
    sov <= 4'h1;
    cyc_wait(10);
    sov <= 4'h0;
    cyc_wait(4);
    sov <= 4'h1;
    cyc_wait(15);
    chk(fl.sink_short_flag, 0, "short count restart");
    cyc_wait(15);
    chk(fl.sink_short_flag, 1, "short flag");
    chk(son, 4'hE, "only ch0 off");
    host.read_flags();
    spol <= 1'b0;
    sov <= 4'h2;
    cyc_wait(30);
    chk(fl.sink_short_flag, 1, "short flag keep");
    chk(son[1], 1, "ch1 kept on");
    sov <= 4'h0;
    blrst <= 1'b1;
    cyc_wait(1);
    blrst <= 1'b0;
    cyc_wait(4);
    host.read_flags();
  endtask : t_short

  task automatic t_ovp();
    @(posedge clk_sys_i);
    ovp <= 1'b1;
    cyc_wait(6);
    chk(brun, 0, "boost stop");
    chk(fl.bl_overvolt_flag, 1, "ovp flag");
    chk(son, 4'hF, "report only");
    ovp <= 1'b0;
    cyc_wait(6);
    chk(brun, 1, "boost resumes");
    opol <= 1'b1;
    lowhr <= 4'h4;
    ovp <= 1'b1;
    cyc_wait(6);
    ovp <= 1'b0;
    lowhr <= 4'h0;
    cyc_wait(6);
    chk(son, 4'hB, "weak sink off");
    blrst <= 1'b1;
    cyc_wait(1);
    blrst <= 1'b0;
    cyc_wait(5);
    chk(son, 4'hF, "mode reset frees");
    lowhr <= 4'hF;
    ovp <= 1'b1;
    cyc_wait(6);
    ovp <= 1'b0;
    lowhr <= 4'h0;
    cyc_wait(6);
    chk(son, 4'h0, "all open off");
    chk(brun, 0, "all open boost");
    host.soft_reset();
    cyc_wait(6);
    chk(son, 4'hF, "soft reset frees");
    chk(sr_seen, 1, "soft reset pulse");
    host.read_flags();
  endtask : t_ovp

  task automatic t_ocp();
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys_i);
      ocsel <= 2'(i);
      cyc_wait(1);
      chk(ocl, 6'(i), "limit select");
    end
    for (int i = 1; i <= 8; i++)
    begin
      @(posedge clk_sys_i);
      ocp <= 1'b1;
      cyc_wait(2);
      ocp <= 1'b0;
      cyc_wait(3);
      chk(lsb, 1, "low side blocked");
      chk(fl.bl_overcurrent_flag, (i == 8), "ocp count");
      cyc <= 1'b1;
      cyc_wait(1);
      cyc <= 1'b0;
      cyc_wait(2);
      chk(lsb, 0, "new cycle frees");
    end
    host.read_flags();
  endtask : t_ocp

  task automatic t_rail();
    @(posedge clk_sys_i);
    rspol <= 2'h2;
    overload <= 1'b1;
    cyc_wait(8);
    chk(fl.pos_rail_short_flag, 0, "filter running");
    cyc_wait(12);
    chk(fl.pos_rail_short_flag, 1, "rail short flag");
    chk(non, 0, "bias off");
    chk(brun, 0, "backlight off");
    overload <= 1'b0;
    cyc_wait(6);
    chk(fl.pos_rail_short_flag, 1, "flag held");
    host.read_flags();
    cyc_wait(3);
    chk(fl.pos_rail_short_flag, 0, "read clears");
    host.soft_reset();
  endtask : t_rail

  task automatic t_misc();
    bbfs_pkg::bbfs_bias_cfg_t c;
    c = '0;
    c.pos_discharge_en = 1'b1;
    host.write_bias(c, 6'h10, 6'h11);
    @(posedge clk_sys_i);
    therm <= 1'b1;
    cyc_wait(6);
    chk(fl.thermal_trip_flag, 1, "thermal flag");
    chk({son, brun, bbrun}, 0, "stages off");
    therm <= 1'b0;
    cyc_wait(6);
    chk(fl.thermal_trip_flag, 0, "thermal clears");
    uvlo <= 1'b1;
    cyc_wait(6);
    chk({son, brun}, 0, "uvlo off");
    uvlo <= 1'b0;
    cyc_wait(6);
    chk(son, 4'hF, "uvlo resume");
    hw_en <= 1'b0;
    cyc_wait(6);
    chk(mode, bbfs_pkg::BBFS_SHUTDOWN, "shutdown");
    chk(rr, 1, "regs held");
    chk({pdis, ndis}, 2'h2, "discharge sel");
  endtask : t_misc

  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    cyc_wait(8);
    chk(mode, bbfs_pkg::BBFS_SHUTDOWN, "enable low");
    hw_en <= 1'b1;
    cyc_wait(6);
    chk(mode, bbfs_pkg::BBFS_STANDBY, "standby");
    t_bias();
    sen <= 4'hF;
    cyc_wait(6);
    t_short();
    t_ovp();
    t_ocp();
    t_rail();
    sen <= 4'hF;
    cyc_wait(6);
    t_misc();
    end_of_test();
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    errors++;
    end_of_test();
  end
endmodule : bbfs_top_tb
